// ---- hw/fifo_port_device.sv ----
// device end of the asynchronous byte fifo port
`timescale 1ns/1ns
module fifo_port_device (
    input wire logic sys_clk,
    input wire logic rst,
    fifo_port_if.device pins,
    input wire fifo_port_pkg::port_mode_t port_mode,
    input wire logic usb_suspended,
    input wire logic remote_wake_en,
    input wire fifo_port_pkg::byte_t rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output fifo_port_pkg::byte_t tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic resume_req,
    output logic flush_req
);
    import fifo_port_pkg::*;

    logic enabled;
    logic rd_q, rd_d, wr_q, wr_d, send_now_wake_n_q, send_now_wake_n_d;
    logic rd_fall, rd_rise, wr_fall, send_now_wake_n_fall;
    byte_t out_q, out_d;
    logic oe_q, oe_d;
    logic rxf_q, rxf_d, txe_q, txe_d, flag_oe_q, flag_oe_d;
    logic hold_q, hold_d;
    byte_t hold_byte_q, hold_byte_d;
    byte_t skid_q [SKID_DEPTH];
    byte_t skid_d [SKID_DEPTH];
    logic [SKID_PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [SKID_CNT_W-1:0] cnt_q, cnt_d;
    logic skid_full, skid_push, skid_pop;
    logic rx_ready_q, rx_ready_d, resume_q, resume_d, flush_q, flush_d;
    logic usb_act_q, usb_act_d, tx_valid_q, tx_valid_d;
    byte_t tx_data_q, tx_data_d;

    // every strobe is judged against its own registered copy, so its rise and fall share one history
    function automatic logic strobe_fell(input logic prev_level, input logic pin_level);
        return prev_level && !pin_level;
    endfunction : strobe_fell

    function automatic logic strobe_rose(input logic prev_level, input logic pin_level);
        return !prev_level && pin_level;
    endfunction : strobe_rose

    assign enabled = (port_mode == PORT_ASYNC_FIFO);
    assign rd_fall = enabled && strobe_fell(rd_q, pins.rd_n);
    assign rd_rise = enabled && strobe_rose(rd_q, pins.rd_n);
    assign wr_fall = enabled && strobe_fell(wr_q, pins.wr_n);
    assign send_now_wake_n_fall = enabled && strobe_fell(send_now_wake_n_q, pins.send_now_wake_n);
    assign skid_full = (cnt_q == SKID_CNT_W'(SKID_DEPTH));
    // a write into a full buffer is dropped; the host must honour the space flag
    assign skid_push = wr_fall && !skid_full;
    assign skid_pop = (cnt_q != '0) && tx_ready;

    always_comb
    begin
        rd_d = pins.rd_n;
        wr_d = pins.wr_n;
        send_now_wake_n_d = pins.send_now_wake_n;
        out_d = out_q;
        // enable follows the sampled strobe, so it lags the pin by one cycle each way
        oe_d = enabled && !pins.rd_n;
        hold_d = hold_q;
        hold_byte_d = hold_byte_q;
        rx_ready_d = 1'b0;
        // a read with nothing held shows the stale byte and advances nothing
        if (rd_fall)
        begin
            out_d = hold_byte_q;
        end
        if (rd_rise && hold_q)
        begin
            hold_d = 1'b0;
        end
        // one-deep holding byte; refilled only between reads so the bus byte is stable
        if (!hold_d && rx_valid && !rx_ready_q && pins.rd_n && enabled)
        begin
            hold_d = 1'b1;
            hold_byte_d = rx_data;
            rx_ready_d = 1'b1;
        end
        flag_oe_d = 1'b1;
        // low only while a byte is held and not mid-read
        rxf_d = !(hold_q && pins.rd_n && enabled && !rd_rise);
        // looks at the next count, so the flag is high from the edge that fills the buffer
        txe_d = !(enabled && (cnt_d != SKID_CNT_W'(SKID_DEPTH)));
        resume_d = send_now_wake_n_fall && usb_suspended && remote_wake_en;
        flush_d = send_now_wake_n_fall && !usb_suspended;
        usb_act_d = usb_suspended;
    end

    always_comb
    begin
        skid_d = skid_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (skid_push)
        begin
            skid_d[wp_q] = pins.parallel_data_bus;
            wp_d = wp_q + 1'b1;
        end
        if (skid_pop)
        begin
            rp_d = rp_q + 1'b1;
        end
        cnt_d = SKID_CNT_W'(cnt_q + SKID_CNT_W'(skid_push) - SKID_CNT_W'(skid_pop));
        // registered copies keep the stream outputs free of decode glitches
        tx_data_d = skid_d[rp_d];
        tx_valid_d = (cnt_d != '0);
    end

    // flag enables drop as soon as reset rises, not at the next clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            send_now_wake_n_q <= 1'b1;
            out_q <= BYTE_ZERO;
            oe_q <= 1'b0;
            rxf_q <= 1'b1;
            txe_q <= 1'b1;
            flag_oe_q <= 1'b0;
            hold_q <= 1'b0;
            hold_byte_q <= BYTE_ZERO;
            rx_ready_q <= 1'b0;
            resume_q <= 1'b0;
            flush_q <= 1'b0;
            usb_act_q <= 1'b1;
        end
        else
        begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            send_now_wake_n_q <= send_now_wake_n_d;
            out_q <= out_d;
            oe_q <= oe_d;
            rxf_q <= rxf_d;
            txe_q <= txe_d;
            flag_oe_q <= flag_oe_d;
            hold_q <= hold_d;
            hold_byte_q <= hold_byte_d;
            rx_ready_q <= rx_ready_d;
            resume_q <= resume_d;
            flush_q <= flush_d;
            usb_act_q <= usb_act_d;
        end
    end

    // the transmit buffer has its own register group, apart from the pin side
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            tx_data_q <= BYTE_ZERO;
            tx_valid_q <= 1'b0;
            for (int i = 0; i < SKID_DEPTH; i++)
            begin
                skid_q[i] <= BYTE_ZERO;
            end
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            tx_data_q <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            skid_q <= skid_d;
        end
    end

    assign pins.dev_data_o = out_q;
    assign pins.dev_data_oe = oe_q;
    assign pins.rx_avail_n_o = rxf_q;
    assign pins.rx_avail_n_oe = flag_oe_q;
    assign pins.tx_space_n_o = txe_q;
    assign pins.tx_space_n_oe = flag_oe_q;
    assign pins.usb_active_n = usb_act_q;
    assign rx_ready = rx_ready_q;
    assign tx_data = tx_data_q;
    assign tx_valid = tx_valid_q;
    assign resume_req = resume_q;
    assign flush_req = flush_q;
endmodule : fifo_port_device

// ---- hw/fifo_port_host.sv ----
// external controller end of the asynchronous byte fifo port
`timescale 1ns/1ns
module fifo_port_host (
    input wire logic sys_clk,
    input wire logic rst,
    fifo_port_if.host pins,
    input wire fifo_port_pkg::byte_t wr_byte,
    input wire logic wr_valid,
    output logic wr_ready,
    output fifo_port_pkg::byte_t rd_byte,
    output logic rd_valid,
    input wire logic rd_en,
    input wire logic send_now
);
    import fifo_port_pkg::*;

    host_state_t st_q, st_d;
    logic [TIMER_W-1:0] tmr_q, tmr_d;
    logic rd_n_q, rd_n_d, wr_n_q, wr_n_d, doe_q, doe_d, send_now_wake_n_q, send_now_wake_n_d;
    byte_t dout_q, dout_d, rdb_q, rdb_d;
    logic rdv_q, rdv_d, wrr_q, wrr_d;

    always_comb
    begin
        st_d = st_q;
        tmr_d = (tmr_q != TIMER_ZERO) ? tmr_q - TIMER_ONE : TIMER_ZERO;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        doe_d = doe_q;
        dout_d = dout_q;
        rdb_d = rdb_q;
        rdv_d = 1'b0;
        wrr_d = 1'b0;
        send_now_wake_n_d = !send_now;
        case (st_q)
            H_IDLE:
            begin
                if (rd_en && !pins.rx_avail_n)
                begin
                    rd_n_d = 1'b0;
                    tmr_d = TIMER_W'(STROBE_LOW_CYC);
                    st_d = H_RD_LOW;
                end
                else if (wr_valid && !pins.tx_space_n)
                begin
                    dout_d = wr_byte;
                    doe_d = 1'b1;
                    wrr_d = 1'b1;
                    tmr_d = TIMER_W'(DATA_SETUP_CYC);
                    st_d = H_WR_SETUP;
                end
            end
            H_RD_LOW:
            begin
                if (tmr_q == TIMER_ZERO)
                begin
                    rdb_d = pins.parallel_data_bus;
                    rdv_d = 1'b1;
                    rd_n_d = 1'b1;
                    tmr_d = TIMER_W'(STROBE_HIGH_CYC);
                    st_d = H_RD_HIGH;
                end
            end
            H_WR_SETUP:
            begin
                if (tmr_q == TIMER_ZERO)
                begin
                    wr_n_d = 1'b0;
                    tmr_d = TIMER_W'(STROBE_LOW_CYC);
                    st_d = H_WR_LOW;
                end
            end
            H_WR_LOW:
            begin
                if (tmr_q == TIMER_ZERO)
                begin
                    wr_n_d = 1'b1;
                    doe_d = 1'b0;
                    tmr_d = TIMER_W'(STROBE_HIGH_CYC);
                    st_d = H_WR_HIGH;
                end
            end
            default:
            begin
                // recovery lets the device flags settle before the next look
                if (tmr_q == TIMER_ZERO)
                begin
                    st_d = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= H_IDLE;
            tmr_q <= TIMER_ZERO;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            doe_q <= 1'b0;
            dout_q <= BYTE_ZERO;
            rdb_q <= BYTE_ZERO;
            rdv_q <= 1'b0;
            wrr_q <= 1'b0;
            send_now_wake_n_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            doe_q <= doe_d;
            dout_q <= dout_d;
            rdb_q <= rdb_d;
            rdv_q <= rdv_d;
            wrr_q <= wrr_d;
            send_now_wake_n_q <= send_now_wake_n_d;
        end
    end

    assign pins.rd_n = rd_n_q;
    assign pins.wr_n = wr_n_q;
    assign pins.host_data_o = dout_q;
    assign pins.host_data_oe = doe_q;
    assign pins.send_now_wake_n = send_now_wake_n_q;
    assign rd_byte = rdb_q;
    assign rd_valid = rdv_q;
    assign wr_ready = wrr_q;
endmodule : fifo_port_host

// ---- hw/fifo_port_if.sv ----
// pin-level link between the byte fifo port and its external controller
`timescale 1ns/1ns
interface fifo_port_if;
    import fifo_port_pkg::*;
    logic rd_n;
    logic wr_n;
    logic send_now_wake_n;
    logic usb_active_n;
    logic rx_avail_n_o;
    logic rx_avail_n_oe;
    logic tx_space_n_o;
    logic tx_space_n_oe;
    byte_t dev_data_o;
    logic dev_data_oe;
    byte_t host_data_o;
    logic host_data_oe;
    // resolved pin levels; undriven flags read high through the pull-ups
    logic rx_avail_n;
    logic tx_space_n;
    byte_t parallel_data_bus;
    assign rx_avail_n = rx_avail_n_oe ? rx_avail_n_o : 1'b1;
    assign tx_space_n = tx_space_n_oe ? tx_space_n_o : 1'b1;
    assign parallel_data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : BYTE_ZERO);
    modport device (
        input rd_n, wr_n, send_now_wake_n, parallel_data_bus,
        output rx_avail_n_o, rx_avail_n_oe, tx_space_n_o, tx_space_n_oe,
        output dev_data_o, dev_data_oe, usb_active_n
    );
    modport host (
        input rx_avail_n, tx_space_n, parallel_data_bus, usb_active_n,
        output rd_n, wr_n, send_now_wake_n, host_data_o, host_data_oe
    );
endinterface : fifo_port_if

// ---- hw/fifo_port_pkg.sv ----
// shared constants and types for the asynchronous byte fifo port
package fifo_port_pkg;
    localparam int DATA_W = 8;
    localparam int SKID_DEPTH = 2;
    localparam int SKID_PTR_W = 1;
    localparam int SKID_CNT_W = 2;
    // strobe timing, host end, in ns at sys_clk
    localparam int CLK_PERIOD_NS = 4;
    localparam int STROBE_LOW_NS = 20;
    localparam int STROBE_HIGH_NS = 20;
    localparam int DATA_SETUP_NS = 8;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 4;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 4'h0;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 4'h1;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    typedef logic [DATA_W-1:0] byte_t;
    typedef enum logic [1:0] {PORT_ASYNC_FIFO, PORT_SYNC_FIFO, PORT_UART, PORT_OTHER} port_mode_t;
    typedef enum {H_IDLE, H_RD_LOW, H_RD_HIGH, H_WR_SETUP, H_WR_LOW, H_WR_HIGH} host_state_t;
endpackage : fifo_port_pkg

// ---- test/fifo_port_sva.sv ----
// pin-level checks between the two ends of the byte fifo port
`timescale 1ns/1ns
module fifo_port_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic rx_avail_n,
    input wire logic tx_space_n,
    input wire logic rx_avail_n_oe,
    input wire logic tx_space_n_oe,
    input wire logic dev_data_oe,
    input wire logic host_data_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // reset itself is the condition, so this one cannot be disabled by it
    a_rst_flags_float: assert property (disable iff (1'b0)
        rst && $past(rst) |-> !rx_avail_n_oe && !tx_space_n_oe)
        else $error("flag driven during reset");
    a_read_after_avail: assert property ($fell(rd_n) |-> $past(!rx_avail_n))
        else $error("read started without data");
    a_rd_flag_high: assert property ($rose(rd_n) |=> rx_avail_n)
        else $error("receive flag not high after read");
    a_flag_relower_late: assert property ($fell(rx_avail_n) |-> rd_n && $past(rd_n, 2))
        else $error("receive flag relowered too soon");
    a_data_oe_read: assert property ($fell(rd_n) |=> dev_data_oe [*5])
        else $error("bus not driven during read");
    a_bus_input_idle: assert property (dev_data_oe |->
        (!rd_n || $past(!rd_n)) && !host_data_oe)
        else $error("bus driven outside read");
    a_write_with_space: assert property ($fell(wr_n) |-> $past(!tx_space_n))
        else $error("write while full");
    a_write_data_setup: assert property ($fell(wr_n) |->
        host_data_oe && $past(host_data_oe, 2))
        else $error("write data not set up");
    a_strobe_low_width: assert property ($fell(wr_n) |-> !wr_n [*5])
        else $error("write strobe too short");
    a_full_needs_write: assert property ($rose(tx_space_n) |-> !wr_n)
        else $error("space flag rose without write");
    c_read: cover property ($rose(rd_n));
    c_write: cover property ($rose(wr_n));
    c_full: cover property ($rose(tx_space_n));
endmodule : fifo_port_sva

// ---- test/usb_async_byte_fifo_port_tb.sv ----
// testbench joining both ends of the byte fifo port
`timescale 1ns/1ns
module usb_async_byte_fifo_port_tb;
    import fifo_port_pkg::*;
    logic sys_clk, rst, usb_suspended, remote_wake_en, rx_valid, tx_ready;
    logic wr_valid, rd_en, send_now, rx_ready, tx_valid, resume_req, flush_req;
    logic wr_ready, rd_valid;
    port_mode_t port_mode;
    byte_t rx_data, tx_data, wr_byte, rd_byte;
    int mismatches, compares;
    fifo_port_if bus();
    fifo_port_device fifo_port_device_i (.sys_clk(sys_clk), .rst(rst), .pins(bus),
        .port_mode(port_mode), .usb_suspended(usb_suspended), .remote_wake_en(remote_wake_en),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .resume_req(resume_req),
        .flush_req(flush_req));
    fifo_port_host fifo_port_host_i (.sys_clk(sys_clk), .rst(rst), .pins(bus),
        .wr_byte(wr_byte), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_byte(rd_byte),
        .rd_valid(rd_valid), .rd_en(rd_en), .send_now(send_now));
    fifo_port_sva fifo_port_sva_i (.sys_clk(sys_clk), .rst(rst), .rd_n(bus.rd_n),
        .wr_n(bus.wr_n), .rx_avail_n(bus.rx_avail_n), .tx_space_n(bus.tx_space_n),
        .rx_avail_n_oe(bus.rx_avail_n_oe), .tx_space_n_oe(bus.tx_space_n_oe),
        .dev_data_oe(bus.dev_data_oe), .host_data_oe(bus.host_data_oe));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input byte_t seen, input byte_t exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // bounded wait on a one-cycle handshake pulse, seen at the falling edge
    task automatic wait_pulse(ref logic sig);
        int n;
        for (n = 0; n < 60 && sig !== 1'b1; n++)
            @(negedge sys_clk);
        check(byte_t'(sig), 8'h01);
    endtask : wait_pulse
    task automatic push_rx(input byte_t b);
        @(negedge sys_clk);
        rx_data = b;
        rx_valid = 1'b1;
        @(negedge sys_clk);
        wait_pulse(rx_ready);
        rx_valid = 1'b0;
    endtask : push_rx
    task automatic read_byte(input byte_t exp);
        @(negedge sys_clk);
        rd_en = 1'b1;
        @(negedge sys_clk);
        wait_pulse(rd_valid);
        rd_en = 1'b0;
        check(rd_byte, exp);
    endtask : read_byte
    task automatic write_byte(input byte_t b);
        @(negedge sys_clk);
        wr_byte = b;
        wr_valid = 1'b1;
        @(negedge sys_clk);
        wait_pulse(wr_ready);
        wr_valid = 1'b0;
    endtask : write_byte
    task automatic do_reset(input port_mode_t m);
        rst = 1'b1;
        port_mode = m;
        repeat (4) @(negedge sys_clk);
        check(byte_t'({bus.rx_avail_n, bus.tx_space_n}), 8'h03);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : do_reset
    task automatic strobe(input logic s, input logic w, input int ef, input int er);
        int f, r, k;
        f = 0;
        r = 0;
        k = 0;
        usb_suspended = s;
        remote_wake_en = w;
        @(negedge sys_clk);
        check(byte_t'(bus.usb_active_n), byte_t'(s));
        send_now = 1'b1;
        // count from the raise: the request pulse stands two edges after it
        repeat (13)
        begin
            @(negedge sys_clk);
            k++;
            if (k == 3)
                send_now = 1'b0;
            f += int'(flush_req === 1'b1);
            r += int'(resume_req === 1'b1);
        end
        check(byte_t'(f), byte_t'(ef));
        check(byte_t'(r), byte_t'(er));
    endtask : strobe
    initial
    begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial
    begin
        static byte_t rx_q[3] = '{8'h5a, 8'ha5, 8'h3c};
        mismatches = 0;
        compares = 0;
        {rx_valid, tx_ready, wr_valid, rd_en, send_now} = '0;
        {usb_suspended, remote_wake_en} = '0;
        rx_data = BYTE_ZERO;
        wr_byte = BYTE_ZERO;
        do_reset(PORT_ASYNC_FIFO);
        check(byte_t'({bus.rx_avail_n, bus.tx_space_n}), 8'h02);
        push_rx(rx_q[0]);
        // the next byte is offered while the previous one is being read
        for (int i = 0; i < 3; i++)
        begin
            fork
                read_byte(rx_q[i]);
                if (i < 2)
                    push_rx(rx_q[i + 1]);
            join
        end
        repeat (4) @(negedge sys_clk);
        check(byte_t'(bus.rx_avail_n), 8'h01);
        write_byte(8'h11);
        write_byte(8'h22);
        repeat (12) @(negedge sys_clk);
        check(byte_t'(bus.tx_space_n), 8'h01);
        check(tx_data, 8'h11);
        tx_ready = 1'b1;
        check(byte_t'(tx_valid), 8'h01);
        @(negedge sys_clk);
        check(tx_data, 8'h22);
        @(negedge sys_clk);
        tx_ready = 1'b0;
        check(byte_t'({tx_valid, bus.tx_space_n}), 8'h00);
        strobe(1'b0, 1'b0, 1, 0);
        strobe(1'b1, 1'b1, 0, 1);
        strobe(1'b1, 1'b0, 0, 0);
        do_reset(PORT_UART);
        check(byte_t'(bus.tx_space_n), 8'h01);
        end_of_test();
    end
endmodule : usb_async_byte_fifo_port_tb
